// File: rtl/fcl_loopback.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - channel uses 1..24 slots, never framing bit
// - one instance per channel, chained per frame
// - 56k mode forces bit eight to one
// - 64k mode carries data in all eight bits
// - clear-channel 64k needs contiguous owned slots
// - non-clear 64k uses alternate owned octets
// - unused interleaved octets are sent all ones
// - detector locks at any code phase
// - loop applied early in the ones interval
// - loop removed early in ones after inverse
module fcl_loopback #(
  parameter int unsigned QUAL_CYC = fcl_pkg::CODE_QUAL_CYC,
  parameter int unsigned RESP_CYC = fcl_pkg::RESP_WIN_CYC
) (
  input  wire logic              clock_in,
  input  wire fcl_pkg::fcl_cfg_t cfg_in,
  input  wire fcl_pkg::fcl_line_t line_in,
  input  wire logic              rstn_in,
  output logic                   line_bit_out,
  output logic                   line_stb_out,
  output logic                   chan_bit_out,
  output logic                   chan_stb_out,
  output logic                   loop_active_out,
  output logic                   act_code_out,
  output logic                   deact_code_out,
  output logic                   cfg_bad_out
);

  fcl_pkg::fcl_ctl_t        q;
  fcl_pkg::fcl_ctl_t        n;
  logic [fcl_pkg::SLOTS-1:0] span;
  logic                     bad_cfg;
  logic                     owned;
  logic                     filler;
  logic                     bit8_56;
  logic                     payload;
  logic                     act_lock;
  logic                     deact_lock;
  logic                     ones_ok;

  // timer end points and local names for the states
  localparam int unsigned TW = fcl_pkg::TMR_W;
  localparam logic [TW-1:0] TMR_ONE   = TW'(1);
  localparam logic [TW-1:0] QUAL_LAST = TW'(QUAL_CYC - 1);
  localparam logic [TW-1:0] RESP_LAST = TW'(RESP_CYC - 1);
  localparam fcl_pkg::fcl_state_t ST_IDLE       = fcl_pkg::ST_IDLE;
  localparam fcl_pkg::fcl_state_t ST_ACT_QUAL   = fcl_pkg::ST_ACT_QUAL;
  localparam fcl_pkg::fcl_state_t ST_ACT_WAIT   = fcl_pkg::ST_ACT_WAIT;
  localparam fcl_pkg::fcl_state_t ST_LOOPED     = fcl_pkg::ST_LOOPED;
  localparam fcl_pkg::fcl_state_t ST_DEACT_QUAL = fcl_pkg::ST_DEACT_QUAL;
  localparam fcl_pkg::fcl_state_t ST_DEACT_WAIT = fcl_pkg::ST_DEACT_WAIT;

  // ---------------------------------------------------------------------------
  // slot ownership
  // ---------------------------------------------------------------------------
  // slots a chained instance does not own pass through untouched, except alternate-mode filler octets, which are sent as ones
  always_comb begin
    span    = fcl_pkg::fcl_span(cfg_in.slot_mask);
    // empty mask, or gaps in a clear-channel 64k map
    bad_cfg = (cfg_in.slot_mask == '0)
           || (!cfg_in.alternate && !cfg_in.rate_56k
               && span != cfg_in.slot_mask);
    // framing bit never belongs to the channel
    owned   = !bad_cfg && !line_in.frame_bit && line_in.slot < 5'h18
           && cfg_in.slot_mask[line_in.slot];
    // idle octets between alternate owned octets
    filler  = !bad_cfg && cfg_in.alternate && !line_in.frame_bit
           && line_in.slot < 5'h18 && span[line_in.slot] && !owned;
    bit8_56 = cfg_in.rate_56k && line_in.bit_num == fcl_pkg::BIT8_IDX;
    payload = line_in.stb && owned && !bit8_56;
    ones_ok = q.ones_run >= 6'(fcl_pkg::ONES_QUAL_BITS);
  end

  // ---------------------------------------------------------------------------
  // code detectors on the extracted payload bits
  // ---------------------------------------------------------------------------
  fcl_code_det #(
    .INVERT     (1'b0)
  ) u_act_det (
    .clock_in   (clock_in),
    .rstn_in    (rstn_in),
    .bit_stb_in (q.chan_stb),
    .bit_in     (q.chan_bit),
    .locked_out (act_lock)
  );

  fcl_code_det #(
    .INVERT     (1'b1)
  ) u_deact_det (
    .clock_in   (clock_in),
    .rstn_in    (rstn_in),
    .bit_stb_in (q.chan_stb),
    .bit_in     (q.chan_bit),
    .locked_out (deact_lock)
  );

  // ---------------------------------------------------------------------------
  // bit path and loopback state
  // ---------------------------------------------------------------------------
  always_comb begin
    n          = q;
    n.line_stb = line_in.stb;
    n.chan_stb = payload;
    n.cfg_bad  = bad_cfg;
    if (line_in.stb) begin
      if (owned) begin
        if (bit8_56) begin
          n.line_bit = 1'b1;
        end else begin
          // all eight bits carry data in 64k mode
          n.line_bit = q.loop ? line_in.rx_bit : line_in.user_bit;
        end
      end else if (filler) begin
        n.line_bit = 1'b1;
      end else begin
        n.line_bit = line_in.pass_bit;
      end
    end
    if (payload) begin
      n.chan_bit = line_in.rx_bit;
      if (!line_in.rx_bit) begin
        n.ones_run = 6'h00;
      end else if (!ones_ok) begin
        n.ones_run = q.ones_run + 6'h01;
      end
    end
    n.tmr = q.tmr + TMR_ONE;
    case (q.st)
      ST_IDLE: begin
        n.tmr = '0;
        if (act_lock) begin
          n.st = ST_ACT_QUAL;
        end
      end
      ST_ACT_QUAL: begin
        // code must hold for the whole qualification time
        if (!act_lock) begin
          n.st = ST_IDLE;
        end else if (q.tmr == QUAL_LAST) begin
          n.st  = ST_ACT_WAIT;
          n.tmr = '0;
        end
      end
      ST_ACT_WAIT: begin
        if (act_lock) begin
          n.tmr = '0;
        end else if (ones_ok) begin
          n.st   = ST_LOOPED;
          n.loop = 1'b1;
        end else if (q.tmr == RESP_LAST) begin
          n.st = ST_IDLE;
        end
      end
      ST_LOOPED: begin
        n.tmr = '0;
        if (deact_lock) begin
          n.st = ST_DEACT_QUAL;
        end
      end
      ST_DEACT_QUAL: begin
        if (!deact_lock) begin
          n.st = ST_LOOPED;
        end else if (q.tmr == QUAL_LAST) begin
          n.st  = ST_DEACT_WAIT;
          n.tmr = '0;
        end
      end
      ST_DEACT_WAIT: begin
        if (deact_lock) begin
          n.tmr = '0;
        end else if (ones_ok) begin
          n.st   = ST_IDLE;
          n.loop = 1'b0;
        end else if (q.tmr == RESP_LAST) begin
          n.st = ST_LOOPED;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    n.act_seen   = n.st == ST_ACT_QUAL || n.st == ST_ACT_WAIT;
    n.deact_seen = n.st == ST_DEACT_QUAL || n.st == ST_DEACT_WAIT;
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign line_bit_out    = q.line_bit;
  assign line_stb_out    = q.line_stb;
  assign chan_bit_out    = q.chan_bit;
  assign chan_stb_out    = q.chan_stb;
  assign loop_active_out = q.loop;
  assign act_code_out    = q.act_seen;
  assign deact_code_out  = q.deact_seen;
  assign cfg_bad_out     = q.cfg_bad;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_frame_pass;
    @(posedge clock_in) disable iff (!rstn_in)
    line_in.stb && line_in.frame_bit
      |=> q.line_stb && q.line_bit == $past(line_in.pass_bit);
  endproperty
  a_frame_pass: assert property (p_frame_pass)
    else $error("framing bit was not passed through");

  property p_bit8_one;
    @(posedge clock_in) disable iff (!rstn_in)
    line_in.stb && owned && bit8_56 |=> q.line_bit;
  endproperty
  a_bit8_one: assert property (p_bit8_one)
    else $error("bit eight of a 56k slot was not one");

  property p_loop_data;
    @(posedge clock_in) disable iff (!rstn_in)
    q.loop && payload |=> q.line_bit == $past(line_in.rx_bit);
  endproperty
  a_loop_data: assert property (p_loop_data)
    else $error("looped payload bit differs from received bit");

  property p_filler_ones;
    @(posedge clock_in) disable iff (!rstn_in)
    line_in.stb && filler |=> q.line_bit;
  endproperty
  a_filler_ones: assert property (p_filler_ones)
    else $error("interleaved idle octet bit was not one");

  property p_loop_set;
    @(posedge clock_in) disable iff (!rstn_in)
    $rose(q.loop) |-> $past(q.st) == ST_ACT_WAIT && $past(ones_ok);
  endproperty
  a_loop_set: assert property (p_loop_set)
    else $error("loop applied outside the ones interval");

  property p_loop_clr;
    @(posedge clock_in) disable iff (!rstn_in)
    $fell(q.loop) |-> $past(q.st) == ST_DEACT_WAIT && $past(ones_ok);
  endproperty
  a_loop_clr: assert property (p_loop_clr)
    else $error("loop removed outside the ones interval");

  property p_qual_drop;
    @(posedge clock_in) disable iff (!rstn_in)
    q.st == ST_ACT_QUAL && !act_lock |=> q.st == ST_IDLE ##1 !q.act_seen;
  endproperty
  a_qual_drop: assert property (p_qual_drop)
    else $error("activation kept without a locked code");

  property p_skip_bit8;
    @(posedge clock_in) disable iff (!rstn_in)
    q.chan_stb |-> !($past(cfg_in.rate_56k)
                     && $past(line_in.bit_num) == fcl_pkg::BIT8_IDX);
  endproperty
  a_skip_bit8: assert property (p_skip_bit8)
    else $error("bit eight of a 56k slot was taken as payload");

endmodule : fcl_loopback
`default_nettype wire

// File: shared/fcl_pkg.sv
`default_nettype none
package fcl_pkg;

  // ---------------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CODE_QUAL_MS  = 1000;  // code must persist this long
  localparam int unsigned RESP_WIN_MS   = 2000;  // all-ones response window
  localparam int unsigned CODE_QUAL_CYC = CLK_HZ / 1000 * CODE_QUAL_MS;
  localparam int unsigned RESP_WIN_CYC  = CLK_HZ / 1000 * RESP_WIN_MS;
  localparam int unsigned TMR_W         = 27;    // holds RESP_WIN_CYC

  // ---------------------------------------------------------------------------
  // framing and detector constants
  // ---------------------------------------------------------------------------
  localparam int unsigned SLOTS          = 24;
  localparam logic [2:0]  BIT8_IDX       = 3'h7;  // bit eight of a slot
  localparam int unsigned ONES_QUAL_BITS = 32;    // payload ones to accept
  localparam int unsigned LOCK_BITS      = 64;    // good bits before lock
  localparam int unsigned ERR_LIMIT      = 4;     // errors per window to drop
  localparam int unsigned ERR_WIN_BITS   = 255;   // error window length
  localparam int unsigned RUN_LIMIT      = 8;     // equal bits never in code

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [SLOTS-1:0] slot_mask;  // slots owned by this channel
    logic             rate_56k;   // seven payload bits per slot
    logic             alternate;  // alternate-octet mapping
  } fcl_cfg_t;

  typedef struct packed {
    logic       stb;        // one DS1 bit time
    logic       frame_bit;  // this bit is the framing bit
    logic [4:0] slot;       // slot 0..23
    logic [2:0] bit_num;    // 0 = bit one .. 7 = bit eight
    logic       rx_bit;     // received line bit
    logic       pass_bit;   // outgoing bit from upstream
    logic       user_bit;   // outgoing channel bit from user
  } fcl_line_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ACT_QUAL, ST_ACT_WAIT, ST_LOOPED, ST_DEACT_QUAL, ST_DEACT_WAIT
  } fcl_state_t;

  typedef struct packed {
    fcl_state_t       st;
    logic [TMR_W-1:0] tmr;
    logic [5:0]       ones_run;
    logic             loop;
    logic             act_seen;
    logic             deact_seen;
    logic             cfg_bad;
    logic             line_bit;
    logic             line_stb;
    logic             chan_bit;
    logic             chan_stb;
  } fcl_ctl_t;

  typedef struct packed {
    logic [6:0] hist;
    logic [3:0] run;
    logic [6:0] good;
    logic [2:0] errs;
    logic [7:0] win;
    logic       lock;
  } fcl_det_t;

  // ---------------------------------------------------------------------------
  // slots from lowest to highest owned slot
  // ---------------------------------------------------------------------------
  function automatic logic [SLOTS-1:0] fcl_span(input logic [SLOTS-1:0] m);
    logic [SLOTS-1:0] above;
    logic [SLOTS-1:0] below;
    above[0]       = m[0];
    below[SLOTS-1] = m[SLOTS-1];
    for (int i = 1; i < SLOTS; i++) begin
      above[i]         = above[i-1] | m[i];
      below[SLOTS-1-i] = below[SLOTS-i] | m[SLOTS-1-i];
    end
    return above & below;
  endfunction : fcl_span

endpackage : fcl_pkg
`default_nettype wire

// File: rtl/fcl_code_det.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_code_det #(
  parameter logic INVERT = 1'b0
) (
  input  wire logic clock_in,
  input  wire logic rstn_in,
  input  wire logic bit_stb_in,
  input  wire logic bit_in,
  output logic      locked_out
);

  fcl_pkg::fcl_det_t q;
  fcl_pkg::fcl_det_t n;
  logic              pred;
  logic [3:0]        run_n;
  logic              bad;

  // ---------------------------------------------------------------------------
  // self-synchronising check of the seven-stage sequence
  // ---------------------------------------------------------------------------
  // prediction uses only past bits, so any start phase locks
  always_comb begin
    n     = q;
    pred  = q.hist[2] ^ q.hist[6] ^ INVERT;
    run_n = (bit_in == q.hist[0])
          ? ((q.run == 4'hF) ? q.run : q.run + 4'h1) : 4'h1;
    // a long equal run is all ones/zeros, never the code
    bad   = (bit_in != pred) || (run_n >= 4'(fcl_pkg::RUN_LIMIT));
    if (bit_stb_in) begin
      n.hist = {q.hist[5:0], bit_in};
      n.run  = run_n;
      if (!q.lock) begin
        // qualify on a clean run
        n.good = bad ? 7'h00 : q.good + 7'h01;
        n.lock = !bad && (q.good == 7'(fcl_pkg::LOCK_BITS - 1));
        n.errs = 3'h0;
        n.win  = 8'h00;
      end else begin
        // tolerate sparse errors inside a window
        n.errs = q.errs + {2'h0, bad};
        n.win  = q.win + 8'h01;
        if (n.errs == 3'(fcl_pkg::ERR_LIMIT)) begin
          n.lock = 1'b0;
          n.good = 7'h00;
          n.errs = 3'h0;
          n.win  = 8'h00;
        end else if (q.win == 8'(fcl_pkg::ERR_WIN_BITS - 1)) begin
          n.errs = 3'h0;
          n.win  = 8'h00;
        end
      end
    end
  end

  // state register
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign locked_out = q.lock;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_run_breaks;
    @(posedge clock_in) disable iff (!rstn_in)
    bit_stb_in && !q.lock && bad |=> q.good == 7'h00 && !q.lock;
  endproperty
  a_run_breaks: assert property (p_run_breaks)
    else $error("detector kept counting after a bad bit");

  property p_lock_needs_run;
    @(posedge clock_in) disable iff (!rstn_in)
    !q.lock ##1 q.lock |-> $past(q.good) == 7'(fcl_pkg::LOCK_BITS - 1);
  endproperty
  a_lock_needs_run: assert property (p_lock_needs_run)
    else $error("detector locked without a full clean run");

endmodule : fcl_code_det
`default_nettype wire

// File: bench/fcl_far_end.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// far-end terminal: frames the line and sends codes in the channel
// ---------------------------------------------------------------------------
module fcl_far_end (
  input  wire logic              clock_in,
  input  wire logic              rstn_in,
  input  wire fcl_pkg::fcl_cfg_t cfg_in,
  input  wire logic [1:0]        mode_in,   // 0 zeros, 1 act, 2 deact, 3 ones
  input  wire logic [6:0]        seed_in,   // must be nonzero
  output var  fcl_pkg::fcl_line_t line_out
);
  logic [7:0] pos_q;   // 0 framing bit, 1..192 slot bits
  logic [6:0] gen_q;   // seven-stage code generator
  logic [4:0] slot_w;
  logic       pay_w;
  logic       code_w;

  // payload position and next code bit
  always_comb begin
    slot_w = 5'((pos_q - 8'h01) >> 3);
    pay_w  = pos_q != 8'h00 && cfg_in.slot_mask[slot_w] &&
             !(cfg_in.rate_56k && pos_q[2:0] == 3'h0);
    code_w = gen_q[6] ^ gen_q[2] ^ (mode_in == 2'h2);
  end

  // one line bit per cycle, code bits only in payload
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pos_q    <= 8'h00;
      gen_q    <= seed_in;
      line_out <= '0;
    end else begin
      pos_q              <= (pos_q == 8'hC0) ? 8'h00 : pos_q + 8'h01;
      line_out.stb       <= 1'b1;
      line_out.frame_bit <= pos_q == 8'h00;
      line_out.slot      <= slot_w;
      line_out.bit_num   <= pos_q[2:0] - 3'h1;
      line_out.pass_bit  <= pos_q[1];
      line_out.user_bit  <= ~pos_q[0];
      if (mode_in == 2'h0) begin
        gen_q <= seed_in;
      end else if (pay_w) begin
        gen_q <= {gen_q[5:0], gen_q[6] ^ gen_q[2]};
      end
      if (!pay_w) begin
        line_out.rx_bit <= pos_q[0];
      end else if (mode_in == 2'h3) begin
        line_out.rx_bit <= 1'b1;
      end else begin
        line_out.rx_bit <= (mode_in == 2'h0) ? 1'b0 : code_w;
      end
    end
  end
endmodule : fcl_far_end
`default_nettype wire

// File: bench/fcl_loopback_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fcl_loopback_tb;
  localparam int unsigned QC = 400;
  localparam int unsigned RC = 2000;
  localparam fcl_pkg::fcl_cfg_t CODE_CFG = '{24'h000038, 1'b1, 1'b0};

  logic               clock_in;
  logic               rstn_in;
  fcl_pkg::fcl_cfg_t  cfg_in;
  fcl_pkg::fcl_line_t line_in;
  logic [1:0]         mode;
  logic [6:0]         seed;
  logic               line_bit_out;
  logic               line_stb_out;
  logic               chan_bit_out;
  logic               chan_stb_out;
  logic               loop_active_out;
  logic               act_code_out;
  logic               deact_code_out;
  logic               cfg_bad_out;
  int                 err_total;
  int                 check_count;
  logic               exp_loop;

  fcl_loopback #(.QUAL_CYC(QC), .RESP_CYC(RC)) fcl_loopback_i (
    .clock_in(clock_in), .cfg_in(cfg_in), .line_in(line_in),
    .rstn_in(rstn_in), .line_bit_out(line_bit_out),
    .line_stb_out(line_stb_out), .chan_bit_out(chan_bit_out),
    .chan_stb_out(chan_stb_out), .loop_active_out(loop_active_out),
    .act_code_out(act_code_out), .deact_code_out(deact_code_out),
    .cfg_bad_out(cfg_bad_out));

  fcl_far_end fcl_far_end_i (
    .clock_in(clock_in), .rstn_in(rstn_in), .cfg_in(cfg_in),
    .mode_in(mode), .seed_in(seed), .line_out(line_in));

  always #10 clock_in = ~clock_in;

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk

  function automatic logic cfg_is_bad(input fcl_pkg::fcl_cfg_t c);
    int lo;
    int hi;
    lo = -1;
    hi = -1;
    for (int i = 0; i < 24; i++) if (c.slot_mask[i]) begin
      if (lo < 0) lo = i;
      hi = i;
    end
    if (lo < 0) return 1'b1;
    if (c.alternate || c.rate_56k) return 1'b0;
    for (int i = lo; i <= hi; i++) if (!c.slot_mask[i]) return 1'b1;
    return 1'b0;
  endfunction : cfg_is_bad

  function automatic logic in_span(input logic [23:0] m, input int s);
    logic a;
    logic b;
    a = 1'b0;
    b = 1'b0;
    for (int i = 0; i < 24; i++) if (m[i]) begin
      if (i <= s) a = 1'b1;
      if (i >= s) b = 1'b1;
    end
    return a && b;
  endfunction : in_span

  function automatic logic flag(input int idx);
    case (idx)
      0: return act_code_out;
      1: return deact_code_out;
      default: return loop_active_out;
    endcase
  endfunction : flag

  task automatic wait_flag(input string what, input int idx,
                           input logic val, input int lim);
    int n;
    n = 0;
    #1;
    while (flag(idx) !== val && n < lim) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(what, val, flag(idx));
  endtask : wait_flag

  // judge every line bit against the mapping worked out here
  task automatic run_line(input int n);
    fcl_pkg::fcl_line_t l;
    logic bad;
    logic own;
    logic pay;
    logic eb;
    repeat (n) begin
      @(posedge clock_in);
      l   = line_in;
      bad = cfg_is_bad(cfg_in);
      own = !bad && !l.frame_bit && l.slot < 5'h18 &&
            cfg_in.slot_mask[l.slot];
      pay = own && !(cfg_in.rate_56k && l.bit_num == 3'h7);
      if (own && !pay) eb = 1'b1;
      else if (own) eb = exp_loop ? l.rx_bit : l.user_bit;
      else if (!bad && !l.frame_bit && cfg_in.alternate &&
               l.slot < 5'h18 && in_span(cfg_in.slot_mask, int'(l.slot)))
        eb = 1'b1;
      else eb = l.pass_bit;
      #1;
      chk("line_stb_out", l.stb, line_stb_out);
      chk("line_bit_out", eb, line_bit_out);
      chk("chan_stb_out", pay, chan_stb_out);
      if (pay) chk("chan_bit_out", l.rx_bit, chan_bit_out);
      chk("cfg_bad_out", bad, cfg_bad_out);
    end
  endtask : run_line

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    #1;
    chk("loop_active_out", 1'b0, loop_active_out);
    chk("act_code_out", 1'b0, act_code_out);
    chk("line_stb_out", 1'b0, line_stb_out);
  endtask : t_reset

  task automatic t_cfg;
    fcl_pkg::fcl_cfg_t tbl [6];
    tbl = '{'{24'h00000F, 1'b0, 1'b0}, '{24'h000F00, 1'b1, 1'b0},
            '{24'h000555, 1'b0, 1'b1}, '{24'h000505, 1'b0, 1'b0},
            '{24'h000000, 1'b1, 1'b0}, '{24'hFFFFFF, 1'b1, 1'b0}};
    foreach (tbl[i]) begin
      @(posedge clock_in);
      cfg_in <= tbl[i];
      run_line(200);
    end
  endtask : t_cfg

  task automatic t_refuse;
    @(posedge clock_in);
    cfg_in <= CODE_CFG;
    mode   <= 2'h2;
    repeat (1200) @(posedge clock_in);
    #1;
    chk("deact_code_out", 1'b0, deact_code_out);
    chk("loop_active_out", 1'b0, loop_active_out);
    @(posedge clock_in);
    mode <= 2'h0;
    seed <= 7'h5A;
  endtask : t_refuse

  task automatic t_activate;
    @(posedge clock_in);
    mode <= 2'h1;
    wait_flag("act_code_out", 0, 1'b1, 1500);
    chk("loop_active_out", 1'b0, loop_active_out);
    repeat (QC + 200) @(posedge clock_in);
    #1;
    chk("act_code_out", 1'b1, act_code_out);
    chk("loop_active_out", 1'b0, loop_active_out);
    @(posedge clock_in);
    mode <= 2'h3;
    wait_flag("loop_active_out", 2, 1'b1, RC);
    chk("act_code_out", 1'b0, act_code_out);
    exp_loop = 1'b1;
    run_line(200);
  endtask : t_activate

  task automatic t_deactivate;
    @(posedge clock_in);
    mode <= 2'h2;
    wait_flag("deact_code_out", 1, 1'b1, 1500);
    chk("loop_active_out", 1'b1, loop_active_out);
    repeat (QC + 200) @(posedge clock_in);
    #1;
    chk("deact_code_out", 1'b1, deact_code_out);
    chk("loop_active_out", 1'b1, loop_active_out);
    @(posedge clock_in);
    mode <= 2'h3;
    wait_flag("loop_active_out", 2, 1'b0, RC);
    chk("deact_code_out", 1'b0, deact_code_out);
    exp_loop = 1'b0;
    run_line(200);
  endtask : t_deactivate

  task automatic t_timeout;
    @(posedge clock_in);
    mode <= 2'h1;
    wait_flag("act_code_out", 0, 1'b1, 1500);
    // code lost inside the qualification time falls back to idle
    @(posedge clock_in);
    mode <= 2'h2;
    wait_flag("act_code_out", 0, 1'b0, QC);
    chk("loop_active_out", 1'b0, loop_active_out);
    @(posedge clock_in);
    mode <= 2'h1;
    wait_flag("act_code_out", 0, 1'b1, 1500);
    repeat (QC + 200) @(posedge clock_in);
    mode <= 2'h0;
    repeat (RC / 2) @(posedge clock_in);
    #1;
    chk("act_code_out", 1'b1, act_code_out);
    wait_flag("act_code_out", 0, 1'b0, RC + 1000);
    chk("loop_active_out", 1'b0, loop_active_out);
  endtask : t_timeout

  // ---------------------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    clock_in    = 1'b0;
    rstn_in     = 1'b0;
    cfg_in      = '0;
    mode        = 2'h0;
    seed        = 7'h01;
    err_total   = 0;
    check_count = 0;
    exp_loop    = 1'b0;
    t_reset();
    t_cfg();
    t_refuse();
    t_activate();
    t_deactivate();
    t_timeout();
    wrap_up();
  end

  // cut a hang short after far more than the expected run
  initial begin
    #1_000_000;
    err_total++;
    $display("[FAIL] watchdog expected done seen hang");
    wrap_up();
  end
endmodule : fcl_loopback_tb
`default_nettype wire
